// ===== hdl/ppm_dev_end.sv
// ppm_dev_end: media-side port device. Serialises request pairs onto the
// transmit line, deserialises the receive line onto the indicate path,
// drives loopback and transmitter enable. Registers over APB.
// Assumes line pins are asynchronous to pclk and one line bit per pclk.
`timescale 1ns/1ps
module ppm_dev_end
	import ppm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	ppm_port_if.dev port,
	input wire logic recovered_clock_locked,
	input wire logic line_signal_present,
	input wire logic rx_serial_p,
	input wire logic rx_serial_n,
	input wire logic tx_enable_polarity_sel,
	output logic tx_serial_p,
	output logic tx_serial_n,
	output logic ext_loop_enable_out,
	output logic loop_serial_out_p,
	output logic loop_serial_out_n,
	output logic optical_tx_enable_out
);
	import ppm_pkg::*;

	// pin synchronisers: three stages, change accepted once stages 2 and 3 agree
	wire [PPM_PIN_SYNC_W-1:0] pin_raw;
	logic [PPM_PIN_SYNC_W-1:0] pin_s1_ff;
	logic [PPM_PIN_SYNC_W-1:0] pin_s2_ff;
	logic [PPM_PIN_SYNC_W-1:0] pin_s3_ff;
	logic [PPM_PIN_SYNC_W-1:0] pin_ok_ff;
	assign pin_raw = {tx_enable_polarity_sel, rx_serial_n, rx_serial_p,
		line_signal_present, recovered_clock_locked};

	genvar gi;
	generate
		for (gi = 0; gi < PPM_PIN_SYNC_W; gi++)
		begin : g_pin
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pin_s1_ff[gi] <= 1'b0;
					pin_s2_ff[gi] <= 1'b0;
					pin_s3_ff[gi] <= 1'b0;
					pin_ok_ff[gi] <= 1'b0;
				end
				else
				begin
					pin_s1_ff[gi] <= pin_raw[gi];
					pin_s2_ff[gi] <= pin_s1_ff[gi];
					pin_s3_ff[gi] <= pin_s2_ff[gi];
					if (pin_s2_ff[gi] == pin_s3_ff[gi])
						pin_ok_ff[gi] <= pin_s3_ff[gi];
				end
			end
		end
	endgenerate

	wire locked = pin_ok_ff[0];
	wire sig_present = pin_ok_ff[1];
	// the agreement stage drops one-cycle pulses, so a run of equal line bits must stand two pclk cycles
	wire rx_bit = pin_ok_ff[2] & ~pin_ok_ff[3]; // differential pair
	wire pol_sel = pin_ok_ff[4];

	// registers
	logic [2:0] mode_ff;
	logic [2:0] tx_state_ff;
	logic [PPM_ERR_CNT_W-1:0] err_cnt_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;

	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire hit_mode = (paddr == PPM_OFF_MODE);
	wire hit_state = (paddr == PPM_OFF_TX_STATE);
	wire hit_stat = (paddr == PPM_OFF_STATUS);
	wire hit_any = hit_mode | hit_state | hit_stat;
	wire wr_mode = access & pwrite & hit_mode;
	wire wr_state = access & pwrite & hit_state;
	wire tx_mode_bit = mode_ff[PPM_MODE_TX_EN_BIT];
	wire loop_on = mode_ff[PPM_MODE_LOOP_BIT];
	wire rx_ctrl = mode_ff[PPM_MODE_RX_CTRL_BIT];

	wire [31:0] stat_word = {16'h0000, err_cnt_ff, 6'h00, sig_present, locked};
	wire [31:0] nxt_prdata = hit_mode ? {29'h0, mode_ff} :
		hit_state ? {29'h0, tx_state_ff} :
		hit_stat ? stat_word : 32'h00000000;

	// read data is fetched in the setup cycle so access always completes at once
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_ff <= PPM_MODE_RST;
			tx_state_ff <= PPM_TX_STATE_RST;
			prdata_ff <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			if (wr_mode)
				mode_ff <= pwdata[2:0];
			if (wr_state)
				tx_state_ff <= pwdata[2:0];
			if (setup)
			begin
				prdata_ff <= nxt_prdata;
				pslverr_ff <= ~hit_any;
			end
		end
	end

	// byte timing: one pair per eight line bits
	logic [2:0] bit_cnt_ff;
	wire pair_edge = (bit_cnt_ff == 3'(PPM_BITS_PER_PAIR - 1));
	wire req_odd = ^{port.req_parity, port.req_ctrl_flag, port.req_symbol_pair};

	// transmit shifter: msb of first symbol goes out first
	logic [7:0] tx_sh_ff;
	logic tx_p_ff;
	logic tx_n_ff;
	logic loop_en_ff;
	logic loop_p_ff;
	logic loop_n_ff;
	wire [7:0] nxt_tx_sh = pair_edge ? port.req_symbol_pair : {tx_sh_ff[6:0], 1'b0};
	wire tx_bit = tx_sh_ff[7];

	// a pair with bad parity is still sent; the count lets software see it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_cnt_ff <= 3'h0;
			tx_sh_ff <= PPM_PAIR_RST;
			err_cnt_ff <= PPM_ERR_CNT_RST;
		end
		else
		begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			tx_sh_ff <= nxt_tx_sh;
			if (pair_edge && !req_odd && err_cnt_ff != 8'hFF)
				err_cnt_ff <= err_cnt_ff + 8'h01;
		end
	end

	// line outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_p_ff <= 1'b0;
			tx_n_ff <= 1'b1;
			loop_en_ff <= 1'b0;
			loop_p_ff <= 1'b1;
			loop_n_ff <= 1'b0;
		end
		else
		begin
			tx_p_ff <= tx_bit;
			tx_n_ff <= ~tx_bit;
			loop_en_ff <= loop_on;
			loop_p_ff <= loop_on ? tx_bit : 1'b1;
			loop_n_ff <= loop_on ? ~tx_bit : 1'b0;
		end
	end

	// transmitter enable: polarity input inverts the sense of "on"
	wire off_state = (tx_state_ff == PPM_OFF_TX_STATE_CODE);
	wire tx_on = tx_mode_bit & ~off_state;
	wire nxt_tx_en_out = tx_on ? pol_sel : ~pol_sel;
	logic tx_en_out_ff;

	// receive deserialiser: indicate stays at zero pair until clock and signal present
	logic [7:0] rx_sh_ff;
	logic [7:0] ind_pair_ff;
	logic ind_ctrl_ff;
	logic ind_par_ff;
	wire line_ok = locked & sig_present;
	wire [7:0] rx_word = {rx_sh_ff[6:0], rx_bit};
	wire [7:0] nxt_ind_pair = line_ok ? rx_word : PPM_PAIR_RST;
	wire nxt_ind_ctrl = rx_ctrl;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_en_out_ff <= 1'b0;
			rx_sh_ff <= PPM_PAIR_RST;
			ind_pair_ff <= PPM_PAIR_RST;
			ind_ctrl_ff <= 1'b0;
			ind_par_ff <= 1'b1;
		end
		else
		begin
			tx_en_out_ff <= nxt_tx_en_out;
			rx_sh_ff <= rx_word;
			if (pair_edge)
			begin
				ind_pair_ff <= nxt_ind_pair;
				ind_ctrl_ff <= nxt_ind_ctrl;
				ind_par_ff <= ~^{nxt_ind_ctrl, nxt_ind_pair};
			end
		end
	end

	// one port of the dual variant; a second instance forms the other port
	assign port.ind_symbol_pair = ind_pair_ff;
	assign port.ind_ctrl_flag = ind_ctrl_ff;
	assign port.ind_parity = ind_par_ff;
	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = pslverr_ff;
	assign tx_serial_p = tx_p_ff;
	assign tx_serial_n = tx_n_ff;
	assign ext_loop_enable_out = loop_en_ff;
	assign loop_serial_out_p = loop_p_ff;
	assign loop_serial_out_n = loop_n_ff;
	assign optical_tx_enable_out = tx_en_out_ff;
endmodule

// ===== hdl/ppm_pkg.sv
// ppm_pkg: constants shared by the media-side port device, the symbol
// source end and the bench. Assumes a single 50 MHz pclk.
package ppm_pkg;
	localparam int PPM_CLK_HZ = 50000000;
	localparam int PPM_LINE_BPS = 125000000;
	localparam int PPM_BITS_PER_PAIR = 8;
	localparam int PPM_SYM_W = 4;
	localparam int PPM_PAIR_W = 2 * PPM_SYM_W;
	localparam int PPM_PIN_SYNC_W = 5;
	localparam logic [7:0] PPM_OFF_MODE = 8'h00;
	localparam logic [7:0] PPM_OFF_TX_STATE = 8'h04;
	localparam logic [7:0] PPM_OFF_STATUS = 8'h08;
	localparam int PPM_MODE_TX_EN_BIT = 0;
	localparam int PPM_MODE_LOOP_BIT = 1;
	localparam int PPM_MODE_RX_CTRL_BIT = 2;
	localparam logic [2:0] PPM_MODE_RST = 3'h0;
	localparam logic [2:0] PPM_TX_STATE_RST = 3'h0;
	localparam logic [2:0] PPM_OFF_TX_STATE_CODE = 3'h0;
	localparam int PPM_STAT_LOCK_BIT = 0;
	localparam int PPM_STAT_SIG_BIT = 1;
	localparam int PPM_STAT_ERR_LSB = 8;
	localparam int PPM_ERR_CNT_W = 8;
	localparam logic [7:0] PPM_ERR_CNT_RST = 8'h00;
	localparam logic [7:0] PPM_PAIR_RST = 8'h00;
endpackage

// ===== hdl/ppm_port_if.sv
// ppm_port_if: request and indicate paths between the symbol source end
// and the media-side device. Both ends run on the same pclk.
`timescale 1ns/1ps
interface ppm_port_if;
	logic req_parity;
	logic req_ctrl_flag;
	logic [7:0] req_symbol_pair;
	logic ind_parity;
	logic ind_ctrl_flag;
	logic [7:0] ind_symbol_pair;

	modport dev
	(
		input req_parity,
		input req_ctrl_flag,
		input req_symbol_pair,
		output ind_parity,
		output ind_ctrl_flag,
		output ind_symbol_pair
	);

	modport src
	(
		output req_parity,
		output req_ctrl_flag,
		output req_symbol_pair,
		input ind_parity,
		input ind_ctrl_flag,
		input ind_symbol_pair
	);
endinterface

// ===== hdl/ppm_src_end.sv
// ppm_src_end: symbol source end; drives the request path and checks the
// indicate path. Assumes user inputs are on pclk.
`timescale 1ns/1ps
module ppm_src_end
	import ppm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	ppm_port_if.src port,
	input wire logic [ppm_pkg::PPM_SYM_W-1:0] tx_first_sym,
	input wire logic [ppm_pkg::PPM_SYM_W-1:0] tx_second_sym,
	input wire logic tx_is_ctrl,
	output logic [ppm_pkg::PPM_PAIR_W-1:0] rx_pair,
	output logic rx_is_ctrl,
	output logic rx_parity_err
);
	import ppm_pkg::*;

	logic req_parity_ff;
	logic req_ctrl_ff;
	logic [7:0] req_pair_ff;
	logic [7:0] rx_pair_ff;
	logic rx_ctrl_ff;
	logic rx_err_ff;
	wire [7:0] nxt_req_pair;
	wire nxt_req_parity;
	wire ind_odd;

	// first symbol high nibble, msb of each symbol highest
	assign nxt_req_pair = {tx_first_sym, tx_second_sym};
	// parity chosen so the ten request bits hold an odd count of ones
	assign nxt_req_parity = ~^{tx_is_ctrl, nxt_req_pair};
	assign ind_odd = ^{port.ind_parity, port.ind_ctrl_flag, port.ind_symbol_pair};

	// request path registered so it never glitches toward the device
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_pair_ff <= PPM_PAIR_RST;
			req_ctrl_ff <= 1'b0;
			req_parity_ff <= 1'b1;
		end
		else
		begin
			req_pair_ff <= nxt_req_pair;
			req_ctrl_ff <= tx_is_ctrl;
			req_parity_ff <= nxt_req_parity;
		end
	end

	// indicate path captured each cycle; bad parity flagged one cycle later, for as long as it stands
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_pair_ff <= PPM_PAIR_RST;
			rx_ctrl_ff <= 1'b0;
			rx_err_ff <= 1'b0;
		end
		else
		begin
			rx_pair_ff <= port.ind_symbol_pair;
			rx_ctrl_ff <= port.ind_ctrl_flag;
			rx_err_ff <= ~ind_odd;
		end
	end

	assign port.req_symbol_pair = req_pair_ff;
	assign port.req_ctrl_flag = req_ctrl_ff;
	assign port.req_parity = req_parity_ff;
	assign rx_pair = rx_pair_ff;
	assign rx_is_ctrl = rx_ctrl_ff;
	assign rx_parity_err = rx_err_ff;
endmodule

// ===== verif/ppm_props.sv
// ppm_props: assertions on the symbol port between the two ends.
// Assumes both ends run on pclk and sees only the port's signals.
`timescale 1ns/1ps
module ppm_props
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req_parity,
	input wire logic req_ctrl_flag,
	input wire logic [7:0] req_symbol_pair,
	input wire logic ind_parity,
	input wire logic ind_ctrl_flag,
	input wire logic [7:0] ind_symbol_pair
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// parity holds every cycle, since both paths are plain levels
	a_ind_odd_par: assert property (^{ind_parity, ind_ctrl_flag, ind_symbol_pair})
		else $error("indicate parity even");
	a_req_odd_par: assert property (^{req_parity, req_ctrl_flag, req_symbol_pair})
		else $error("request parity even");
	// an indicate pair stands for a whole serial byte time
	a_ind_pair_hold: assert property
		($changed(ind_symbol_pair) |=> $stable(ind_symbol_pair)[*7])
		else $error("indicate pair not held");
	a_ind_ctrl_hold: assert property
		($changed(ind_ctrl_flag) |=> $stable(ind_ctrl_flag)[*7])
		else $error("indicate control not held");
	// parity may only move together with what it covers, and must move when control flips under a stable pair
	a_ind_par_follow: assert property
		($changed(ind_parity) |-> $changed({ind_ctrl_flag, ind_symbol_pair}))
		else $error("indicate parity moved alone");
	a_req_par_follow: assert property
		($changed(req_parity) |-> $changed({req_ctrl_flag, req_symbol_pair}))
		else $error("request parity moved alone");
	a_ind_ctrl_par: assert property
		($changed(ind_ctrl_flag) && $stable(ind_symbol_pair) |-> $changed(ind_parity))
		else $error("indicate control flip kept parity");
	a_req_ctrl_par: assert property
		($changed(req_ctrl_flag) && $stable(req_symbol_pair) |-> $changed(req_parity))
		else $error("request control flip kept parity");
endmodule

// ===== verif/test_phy_port_and_media_control.sv
// test_phy_port_and_media_control: source end and device joined by the port.
// Assumes zero-wait APB and one line bit per pclk; alignment is found by rotation.
`timescale 1ns/1ps
module test_phy_port_and_media_control;
	import ppm_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, tx_sym = 8'h00, rx_pat = 8'hCF;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, lock = 1'b0, sig = 1'b0, pol = 1'b0, is_ctrl = 1'b0;
	logic [7:0] rx_pair;
	logic rx_is_ctrl, rx_err, txp, txn, lpe, lpp, lpn, tx_en;
	int failures = 0, samples_checked = 0, cyc = 0;

	ppm_port_if u_ppm_port_if();
	ppm_src_end u_ppm_src_end (.pclk, .presetn, .port(u_ppm_port_if.src),
		.tx_first_sym(tx_sym[7:4]), .tx_second_sym(tx_sym[3:0]), .tx_is_ctrl(is_ctrl),
		.rx_pair(rx_pair), .rx_is_ctrl(rx_is_ctrl), .rx_parity_err(rx_err));
	ppm_dev_end u_ppm_dev_end (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .port(u_ppm_port_if.dev),
		.recovered_clock_locked(lock), .line_signal_present(sig),
		.rx_serial_p(rx_pat[7]), .rx_serial_n(~rx_pat[7]), .tx_enable_polarity_sel(pol),
		.tx_serial_p(txp), .tx_serial_n(txn), .ext_loop_enable_out(lpe),
		.loop_serial_out_p(lpp), .loop_serial_out_n(lpn), .optical_tx_enable_out(tx_en));
	ppm_props u_ppm_props (.pclk, .presetn, .req_parity(u_ppm_port_if.req_parity),
		.req_ctrl_flag(u_ppm_port_if.req_ctrl_flag),
		.req_symbol_pair(u_ppm_port_if.req_symbol_pair),
		.ind_parity(u_ppm_port_if.ind_parity), .ind_ctrl_flag(u_ppm_port_if.ind_ctrl_flag),
		.ind_symbol_pair(u_ppm_port_if.ind_symbol_pair));

	// clock, and a receive line that repeats one byte msb first; every run of equal
	// bits lasts two cycles or more, since the pin agreement stage drops lone bits
	always #10 pclk = ~pclk;
	always @(posedge pclk)
		rx_pat <= {rx_pat[6:0], rx_pat[7]};

	// hang guard well above the few hundred cycles the tests need
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			failures++;
			give_verdict();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// true when the window holds pat at any of the first eight bit offsets from the top
	function automatic logic rot_hit(input logic [7:0] pat, input logic [15:0] w);
		logic h;
		h = 1'b0;
		for (int r = 0; r < 8; r++)
			h |= (w[15-r -: 8] === pat);
		return h;
	endfunction

	// one APB transfer; d is write data or the expected read data
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		chk("pslverr", 32'(e), 32'(pslverr));
		if (!wr)
			chk("prdata", d, prdata);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic t_regs();
		apb(1'b0, 8'h00, 32'h0, 1'b0);
		apb(1'b1, 8'h04, 32'h3, 1'b0);
		apb(1'b0, 8'h04, 32'h3, 1'b0);
		apb(1'b1, 8'h0C, 32'hFF, 1'b1);
		apb(1'b0, 8'h0C, 32'h0, 1'b1);
		$display("regs test done");
	endtask

	// both transmit mode settings, state class and polarity; enable looked at mid-cycle while it stands
	task automatic t_tx_en();
		logic [2:0] s;
		logic e_en;
		for (int i = 0; i < 8; i++)
		begin
			s = i[1] ? 3'h3 : PPM_OFF_TX_STATE_CODE;
			e_en = (i[0] && s != PPM_OFF_TX_STATE_CODE) ? i[2] : !i[2];
			apb(1'b1, 8'h04, {29'h0, s}, 1'b0);
			apb(1'b1, 8'h00, {31'h0, i[0]}, 1'b0);
			pol <= i[2];
			repeat (8) @(posedge pclk);
			@(negedge pclk);
			if (!i[0])
				chk("tx_en", 32'(e_en), 32'(tx_en));
			else
				chk("tx_en", 32'(e_en), 32'(tx_en));
		end
		$display("tx enable test done");
	endtask

	// pair is zero unless locked and signal present
	task automatic t_rx();
		chk("loop_en", 32'h0, 32'(lpe));
		chk("loop_pair", 32'h2, 32'({lpp, lpn}));
		for (int i = 0; i < 4; i++)
		begin
			@(posedge pclk);
			lock <= i[0];
			sig <= i[1];
			repeat (30) @(posedge pclk);
			@(negedge pclk);
			if (i == 3)
				chk("rx_rot", 32'h1, 32'(rot_hit(rx_pair, 16'hCFCF)));
			else
				chk("rx_pair", 32'h0, 32'(rx_pair));
			chk("rx_ctrl", 32'h0, 32'(rx_is_ctrl));
			chk("rx_perr", 32'h0, 32'(rx_err));
		end
		$display("rx test done");
	endtask

	task automatic t_serial();
		logic [15:0] w;
		apb(1'b1, 8'h00, 32'h6, 1'b0);
		tx_sym <= 8'hE2;
		is_ctrl <= 1'b1;
		repeat (20) @(posedge pclk);
		@(negedge pclk);
		chk("loop_en", 32'h1, 32'(lpe));
		chk("rx_ctrl", 32'h1, 32'(rx_is_ctrl));
		for (int k = 0; k < 16; k++)
		begin
			@(negedge pclk);
			w = {w[14:0], txp};
			chk("tx_n", 32'(!txp), 32'(txn));
			chk("loop_p", 32'(txp), 32'(lpp));
		end
		chk("tx_order", 32'h1, 32'(rot_hit(8'hE2, w)));
		apb(1'b0, 8'h08, 32'h3, 1'b0);
		$display("serial test done");
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_tx_en();
		t_rx();
		t_serial();
		give_verdict();
	end
endmodule
